/* File: dv/paged_nvram_async_port_tb_top.sv */
// testbench of the paged memory host controller
`timescale 1ns/1ps
module paged_nvram_async_port_tb_top import pnv_pkg::*;;
	logic              core_clk = 1'b0; // 50 MHz
	logic              rst = 1'b1;      // reset
	logic              req_valid = 1'b0, req_write = 1'b0; // request
	logic [ADDR_W-1:0] req_addr = 17'h0, mem_addr;        // addresses
	logic [DATA_W-1:0] req_wdata = 16'h0, q;              // data
	logic [1:0]        req_lanes = 2'h3, dev_en;          // lanes
	logic              req_ready, rsp_valid, sel_n, wr_n, oe_n, up_n, lo_n, dq_oe, tick = 1'b0;
	logic [DATA_W-1:0] rsp_rdata, dq_o, dq_i, dev_dq;     // buses
	int                n, num_errors = 0, checks_done = 0; // counters
	int                lo_run = 0, lo_max = 0; // select low run, longest run
	// longest run of select low, counted in clock edges
	always @(posedge core_clk)
	begin
		lo_run <= sel_n ? 0 : lo_run + 1;
		if (lo_run > lo_max)
			lo_max <= lo_run;
	end
	initial
	begin
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		tick <= ~tick;
	// released lanes toggle, never keep the last value
	assign dq_i[15:8] = dev_en[1] ? dev_dq[15:8] : dq_oe ? dq_o[15:8] : {8{tick}} ^ 8'h5a;
	assign dq_i[7:0] = dev_en[0] ? dev_dq[7:0] : dq_oe ? dq_o[7:0] : {8{tick}} ^ 8'h5a;
	pnv_host i_dut (.core_clk, .rst, .req_valid, .req_write, .req_addr, .req_wdata, .req_lanes,
		.req_ready, .rsp_valid, .rsp_rdata, .mem_addr, .mem_sel_n(sel_n), .mem_wr_n(wr_n),
		.mem_oe_n(oe_n), .upper_lane_sel_n(up_n), .lower_lane_sel_n(lo_n), .mem_dq_i(dq_i),
		.mem_dq_o(dq_o), .mem_dq_oe(dq_oe));
	pnv_mem_model i_mem (.addr(mem_addr), .sel_n, .wr_n, .oe_n, .lane_n({up_n, lo_n}),
		.dq_in(dq_i), .dq_out(dev_dq), .dq_en(dev_en));
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// one access; n is cycles from ready to done
	task acc(input logic w, input logic [16:0] a, input logic [15:0] d, input logic [1:0] l);
		@(negedge core_clk);
		{req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, w, a, d, l};
		for (n = 0; req_ready !== 1'b1 && n < 50; n++)
			@(negedge core_clk);
		chk("ready", 16'h1, 16'(req_ready));
		req_valid = 1'b0;
		for (n = 0; rsp_valid !== 1'b1 && n < 50; n++)
			@(negedge core_clk);
		chk("done", 16'h1, 16'(rsp_valid));
		q = rsp_rdata;
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task t_word;
		acc(1'b1, 17'h1ffff, 16'hc3a5, 2'h3);
		repeat (10) @(negedge core_clk);
		acc(1'b0, 17'h1ffff, 16'h0, 2'h3);
		chk("word", 16'hc3a5, q);
		// timer run plus one edge for the registered answer
		chk("latency", 16'(CYCLE_CYC + 1), 16'(n));
	endtask
	task t_lanes;
		acc(1'b1, 17'h4, 16'h1234, 2'h3);
		acc(1'b1, 17'h4, 16'habcd, 2'h2);
		acc(1'b0, 17'h4, 16'h0, 2'h3);
		chk("upper write", 16'hab34, q);
		acc(1'b0, 17'h4, 16'h0, 2'h1);
		chk("lower read", 16'h34, {8'h0, q[7:0]});
		chk("upper off", 16'h1, 16'(q[15:8] !== 8'hab));
	endtask
	task t_page;
		for (int c = 0; c < 4; c++)
			acc(1'b1, 17'(17'h0a5c0 + c), 16'(16'h1111 * c), 2'h3);
		for (int c = 0; c < 4; c++)
		begin
			acc(1'b0, 17'(17'h0a5c0 + c), 16'h0, 2'h3);
			chk("page data", 16'(16'h1111 * c), q);
			chk("page fast", 16'h1, 16'(c == 0 || n < CYCLE_CYC));
		end
		acc(1'b0, 17'h1ffff, 16'h0, 2'h3);
		chk("row change", 16'hc3a5, q);
	endtask
	// long run of page reads: select must rest before the low-time limit
	task t_long;
		for (int i = 0; i < 120; i++)
		begin
			acc(1'b0, 17'(17'h0a5c0 + i % 4), 16'h0, 2'h3);
			chk("long data", 16'(16'h1111 * (i % 4)), q);
		end
		chk("select low run", 16'h1, 16'(lo_max <= SEL_LOW_CYC));
	endtask
	initial
	begin
		#100000;
		num_errors++;
		wrap_up();
	end
	initial
	begin
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		t_word();
		t_lanes();
		t_page();
		t_long();
		wrap_up();
	end
endmodule

/* File: dv/pnv_host_props.sv */
// assertions on the host controller pins
`timescale 1ns/1ps
module pnv_host_props
	import pnv_pkg::*;
(
	input wire logic              core_clk,  // clock
	input wire logic              rst,       // reset
	input wire logic              rsp_valid, // done
	input wire logic [ADDR_W-1:0] mem_addr,  // address
	input wire logic              mem_sel_n, // select
	input wire logic              mem_wr_n,  // strobe
	input wire logic              mem_oe_n,  // output enable
	input wire logic              mem_dq_oe  // host drives
);
	logic [CNT_W-1:0] low_cnt; // select low cycles
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// counter, since the limit is far too long to unroll
	always_ff @(posedge core_clk)
		low_cnt <= (rst || mem_sel_n) ? '0 : low_cnt + CNT_ONE;
	prech_hold_a: assert property ($rose(mem_sel_n) |-> mem_sel_n [*3])
		else $error("select high too short");
	read_time_a: assert property ($fell(mem_sel_n) |-> !rsp_valid [*3] ##[1:8] rsp_valid)
		else $error("access answered out of time");
	wr_pulse_a: assert property ($fell(mem_wr_n) |-> !mem_wr_n [*3] ##[1:8] mem_wr_n)
		else $error("strobe pulse length wrong");
	one_strobe_a: assert property ($rose(mem_wr_n) |-> rsp_valid)
		else $error("strobe end not one word");
	col_steady_a: assert property (!mem_sel_n && $changed(mem_addr) |=> $stable(mem_addr))
		else $error("column bits not held");
	sel_low_max_a: assert property (low_cnt <= SEL_LOW_CYC)
		else $error("select low too long");
	no_clash_a: assert property (mem_dq_oe |-> mem_oe_n)
		else $error("host drives while output enabled");
endmodule
bind pnv_host pnv_host_props i_props (.core_clk, .rst, .rsp_valid, .mem_addr, .mem_sel_n,
	.mem_wr_n, .mem_oe_n, .mem_dq_oe);

/* File: dv/pnv_mem_model.sv */
// behavioural model of the memory pins
`timescale 1ns/1ps
module pnv_mem_model
	import pnv_pkg::*;
#(
	parameter int ACC_NS = ACCESS_NS // raise for a slow part
)(
	input  wire logic [ADDR_W-1:0] addr,   // address
	input  wire logic              sel_n,  // select
	input  wire logic              wr_n,   // strobe
	input  wire logic              oe_n,   // output enable
	input  wire logic [1:0]        lane_n, // upper, lower
	input  wire logic [DATA_W-1:0] dq_in,  // bus
	output logic [DATA_W-1:0]      dq_out, // read word
	output logic [1:0]             dq_en   // lanes driven
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // array
	logic [ADDR_W-1:0] lat;                   // latched address
	realtime           t0;                    // access start
	int                acc;                   // access time
	logic              ok = 1'b0;             // data valid
	logic              wr_on = 1'b0;          // write open
	// select fall starts a random access
	always @(negedge sel_n)
	begin
		lat = addr;
		t0 = $realtime;
		acc = ACC_NS;
	end
	// moves under low select: page, or new row; a select fall in the same step wins
	always @(addr)
		if (!sel_n && $realtime != t0)
		begin
			acc = (addr[16:2] == lat[16:2]) ? ACC_NS / 2 - 1 : ACC_NS;
			lat = addr;
			t0 = $realtime;
		end
	// polled, validity is elapsed time
	always #1 ok = !sel_n && ($realtime - t0 >= acc);
	assign dq_en = {2{ok && !oe_n && wr_n}} & ~lane_n;
	assign dq_out = mem[lat];
	// strobe fall opens a write
	always @(negedge wr_n or negedge sel_n)
		if (!wr_n && !sel_n)
		begin
			wr_on = 1'b1;
			lat = addr;
		end
	// first rising edge commits at once
	always @(posedge wr_n or posedge sel_n)
		if (wr_on)
		begin
			if (!lane_n[1])
				mem[lat][15:8] = dq_in[15:8];
			if (!lane_n[0])
				mem[lat][7:0] = dq_in[7:0];
			wr_on = 1'b0;
		end
endmodule

/* File: logic/pnv_host.sv */
// host controller driving the asynchronous paged nonvolatile memory pins
`timescale 1ns/1ps
module pnv_host
	import pnv_pkg::*;
(
	input  wire logic              core_clk,      // system clock
	input  wire logic              rst,           // synchronous reset, active high
	input  wire logic              req_valid,     // user request pending
	input  wire logic              req_write,     // 1 write, 0 read
	input  wire logic [ADDR_W-1:0] req_addr,      // word address
	input  wire logic [DATA_W-1:0] req_wdata,     // write data
	input  wire logic [1:0]        req_lanes,     // bit1 upper, bit0 lower lane
	output logic                   req_ready,     // request taken this cycle
	output logic                   rsp_valid,     // read data / write done pulse
	output logic [DATA_W-1:0]      rsp_rdata,     // captured read data
	output logic [ADDR_W-1:0]      mem_addr,      // address pins
	output logic                   mem_sel_n,     // chip select, active low
	output logic                   mem_wr_n,      // write strobe, active low
	output logic                   mem_oe_n,      // output enable, active low
	output logic                   upper_lane_sel_n, // upper byte select
	output logic                   lower_lane_sel_n, // lower byte select
	input  wire logic [DATA_W-1:0] mem_dq_i,      // data pins as seen
	output logic [DATA_W-1:0]      mem_dq_o,      // data pins driven value
	output logic                   mem_dq_oe      // host drives data pins
);
	pnv_state_t state_reg; // controller state
	pnv_state_t state_next; // next state
	logic [ADDR_W-1:0] row_addr_reg; // address of the open row
	logic row_open_reg; // select held low with a row open
	logic wr_op_reg; // current access is a write
	logic [CNT_W-1:0] sel_low_reg; // cycles select has stayed low
	logic tmr_load; // start a timed wait
	logic [CNT_W-1:0] tmr_count; // length of the wait
	logic tmr_done; // timed wait finished

	// first select-low count at which a take's access, hold and closing edge no longer fit the low-time limit
	localparam int SEL_OLD_CYC = SEL_LOW_CYC - CYCLE_CYC - COL_HOLD_CYC - 1;

	// an access phase is running; decoded once, for access_end
	function automatic logic in_access(input pnv_state_t s);
		return (s == PNV_RD_WAIT) || (s == PNV_WR_PULSE);
	endfunction

	// a row is reused at page speed only for same-row requests under the low-time limit
	wire same_row = row_open_reg && (req_addr[ADDR_W-1:COL_W] == row_addr_reg[ADDR_W-1:COL_W]);
	wire sel_old = (sel_low_reg >= CNT_W'(SEL_OLD_CYC));
	// a stale row closes first, so no take can stretch select past the limit
	wire row_stale = row_open_reg && sel_old;
	wire take = (state_reg == PNV_IDLE || state_reg == PNV_COL_HOLD) && tmr_done && req_valid
		&& !row_stale;
	wire reuse_row = same_row && !sel_old;
	// page column accesses are faster than a full access
	wire [CNT_W-1:0] acc_cyc = reuse_row ? CNT_W'(PAGE_CYC) : CNT_W'(CYCLE_CYC);
	// end of an access phase and end of the column hold
	wire access_end = tmr_done && in_access(state_reg);
	wire hold_end = tmr_done && (state_reg == PNV_COL_HOLD);

	pnv_timer u_timer (
		.core_clk (core_clk),
		.rst      (rst),
		.load     (tmr_load),
		.count    (tmr_count),
		.done     (tmr_done)
	);

	// next state; the timer paces every phase
	always_comb
	begin
		state_next = state_reg;
		tmr_load = 1'b0;
		tmr_count = CNT_ONE;
		case (state_reg)
			PNV_IDLE, PNV_COL_HOLD:
			begin
				if (take)
				begin
					state_next = req_write ? PNV_WR_PULSE : PNV_RD_WAIT;
					tmr_load = 1'b1;
					tmr_count = acc_cyc;
				end
				else if (row_open_reg && tmr_done && (sel_old || !req_valid))
				begin
					// close the row rather than idle with select low
					state_next = PNV_PRECH;
					tmr_load = 1'b1;
					tmr_count = CNT_W'(PRECH_CYC);
				end
			end
			PNV_RD_WAIT, PNV_WR_PULSE:
			begin
				if (tmr_done)
				begin
					// hold column bits past the strobe edge before change
					state_next = PNV_COL_HOLD;
					tmr_load = 1'b1;
					tmr_count = CNT_W'(COL_HOLD_CYC);
				end
			end
			PNV_PRECH:
			begin
				if (tmr_done)
					state_next = PNV_IDLE;
			end
			default:
				state_next = PNV_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge core_clk)
	begin
		if (rst)
			state_reg <= PNV_IDLE;
		else
			state_reg <= state_next;
	end

	// open-row tracking and select-low time
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			row_open_reg <= 1'b0;
			row_addr_reg <= '0;
			sel_low_reg <= '0;
			wr_op_reg <= 1'b0;
		end
		else if (state_next == PNV_PRECH)
		begin
			row_open_reg <= 1'b0;
			sel_low_reg <= '0;
		end
		else
		begin
			if (take)
			begin
				row_open_reg <= 1'b1;
				row_addr_reg <= req_addr;
				wr_op_reg <= req_write;
			end
			if (row_open_reg || take)
				sel_low_reg <= sel_low_reg + CNT_ONE;
		end
	end

	// pin drive; strobe low on the same edge as select fall gives a select-led write
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			mem_addr <= '0;
			mem_sel_n <= 1'b1;
			mem_wr_n <= 1'b1;
			mem_oe_n <= 1'b1;
			upper_lane_sel_n <= 1'b1;
			lower_lane_sel_n <= 1'b1;
			mem_dq_o <= '0;
			mem_dq_oe <= 1'b0;
		end
		else if (take)
		begin
			mem_addr <= req_addr;
			mem_sel_n <= 1'b0;
			mem_wr_n <= !req_write;
			mem_oe_n <= req_write;
			upper_lane_sel_n <= !req_lanes[1];
			lower_lane_sel_n <= !req_lanes[0];
			mem_dq_o <= req_wdata;
			mem_dq_oe <= req_write;
		end
		else if (access_end)
		begin
			// strobe rises first; select stays low for page reuse
			mem_wr_n <= 1'b1;
			mem_oe_n <= 1'b1;
		end
		else if (hold_end)
			mem_dq_oe <= 1'b0;
		if (!rst && state_next == PNV_PRECH)
		begin
			mem_sel_n <= 1'b1;
			mem_dq_oe <= 1'b0;
		end
	end

	// handshake and read capture at end of access time
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end
		else
		begin
			req_ready <= take;
			rsp_valid <= access_end;
			if (tmr_done && state_reg == PNV_RD_WAIT && !wr_op_reg)
				rsp_rdata <= mem_dq_i;
		end
	end
endmodule

/* File: logic/pnv_pkg.sv */
// package of constants for the paged nonvolatile memory host controller
package pnv_pkg;
	localparam int CLK_PERIOD_NS = 20; // core clock period, 50 MHz
	localparam int ADDR_W = 17; // word address width
	localparam int DATA_W = 16; // data bus width
	localparam int COL_W = 2; // column bits within a row
	localparam int LANE_W = 8; // one byte lane
	localparam int ACCESS_NS = 60; // address_access_time / select access
	localparam int CYCLE_NS = 110; // random_cycle_time
	localparam int PAGE_NS = 30; // page_access_time, half of access
	localparam int PRECH_NS = 60; // precharge_min_time, plain default
	localparam int COL_HOLD_NS = 10; // column bits steady time
	localparam int SEL_LOW_US = 10; // longest continuous select low
	// least times round up to whole cycles
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYCLE_CYC = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAGE_CYC = (PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRECH_CYC = (PRECH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int COL_HOLD_CYC = (COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// longest time rounds down
	localparam int SEL_LOW_CYC = (SEL_LOW_US * 1000) / CLK_PERIOD_NS;
	localparam int CNT_W = 10; // width of cycle counters
	localparam logic [CNT_W-1:0] CNT_ONE = 10'h001; // unit step
	localparam logic [1:0] LANES_NONE = 2'h0; // no byte lane
	typedef enum logic [2:0] {
		PNV_IDLE,
		PNV_SETUP,
		PNV_RD_WAIT,
		PNV_WR_PULSE,
		PNV_PRECH,
		PNV_COL_HOLD
	} pnv_state_t;
endpackage

/* File: logic/pnv_timer.sv */
// down-counting cycle timer with a done flag
`timescale 1ns/1ps
module pnv_timer
	import pnv_pkg::*;
(
	input  wire logic             core_clk, // system clock
	input  wire logic             rst,      // synchronous reset, active high
	input  wire logic             load,     // start a new wait
	input  wire logic [CNT_W-1:0] count,    // cycles to wait, at least one
	output logic                  done      // high once the wait has run out
);
	logic [CNT_W-1:0] left_reg; // cycles still to go
	wire  is_last; // last step of a running wait
	assign is_last = (left_reg == CNT_ONE);

	// counter loads, then steps down to zero
	always_ff @(posedge core_clk)
	begin
		if (rst)
			left_reg <= '0;
		else if (load)
			left_reg <= count;
		else if (left_reg != '0)
			left_reg <= left_reg - CNT_ONE;
	end

	// done is registered so callers see a clean level
	always_ff @(posedge core_clk)
	begin
		if (rst)
			done <= 1'b1;
		else if (load)
			done <= 1'b0;
		else if (is_last)
			done <= 1'b1;
	end
endmodule
